// file: design/basic_down_timer.sv
// General-purpose 16-bit down timer with prescaler and APB registers
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - 16-bit down counter decrements once per 8-bit prescaler period.
// - Tick source: core clock/4, oscillator reference, or timer input pin.
// - End of count is underflow from zero; drives reload, output, irq.
// - Run bit set starts counting next cycle; clearing it stops.
// - Restart resumes held value unless new constant written while stopped.
// - Count writes load at next end of count; prescaler writes act now.
// - Count high, count low and prescaler reset to all ones.
// - Single mode: end of count stops, reloads, clears run bit.
// - Continuous mode: end of count reloads and keeps counting.
// - Single select writable any time, together with run bit.
// - Input section off: mode bits and pin ignored, core clock/4 used.
// - Event mode: each falling pin edge is the counting tick.
// - Gated mode: count at core clock/4 only while pin is high.
// - Trigger mode: counting begins after run bit and a falling edge.
// - Retrigger mode: falling edge while running reloads both constants.
// - No-output mode holds the output pin high.
// - Square mode toggles the output pin at every end of count.
// - PWM mode copies output_mode_lo onto the pin at end of count.
// - Route bit 0: timer drives irq channel; 1: external pin does.
// - Four byte registers: count high, count low, prescaler, control.
// - Prescaler value N divides the tick by N plus one.
// - Count writes set reload constant; reads return live counter.
// - Prescaler read returns programmed value, not internal count.
module basic_down_timer #(
	parameter bit HAS_INPUT_PIN = 1'b1
) (
	// APB clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Timer pins and time reference
	input  wire logic        timer_in_pin,
	input  wire logic        osc_time_reference,
	output logic             timer_out_pin,
	// Shared external interrupt channel
	input  wire logic        ext_irq_pin,
	output logic             irq_channel_out
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] cnt;
		logic [15:0] reload;
		logic [7:0]  presc_val;
		logic [7:0]  presc_cnt;
		logic [7:0]  ctrl;
		logic [1:0]  div;
		logic        pend;
		logic        armed;
		logic        out;
		logic        irq;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} timer_state_t;

	timer_state_t s_r;
	timer_state_t s_nxt;

	logic [2:0] pin_lvl, pin_fall, pin_rise;

	// pin synchroniser; interrupt pin idles low, the others high
	pin_sync #(
		.WIDTH     (3),
		.RST_LEVEL (3'h3)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  ({ext_irq_pin, osc_time_reference, timer_in_pin}),
		.level   (pin_lvl),
		.fall    (pin_fall),
		.rise    (pin_rise)
	);

	// ------------------------------------------------------------
	// Decoded control and tick sources
	// ------------------------------------------------------------
	logic       run, single, in_en, div_tick, ev_tick, tick_src;
	logic       retrig, count_tick, eoc, acc, wr, setup;
	logic       hit_hi, hit_lo, hit_ps, hit_ct;
	logic [1:0] in_mode, out_mode;

	assign run      = s_r.ctrl[down_timer_pkg::BIT_RUN];
	assign single   = s_r.ctrl[down_timer_pkg::BIT_SINGLE];
	assign in_en    = s_r.ctrl[down_timer_pkg::BIT_IN_ENABLE];
	assign in_mode  = {s_r.ctrl[down_timer_pkg::BIT_IN_MODE_HI],
	                   s_r.ctrl[down_timer_pkg::BIT_IN_MODE_LO]};
	assign out_mode = {s_r.ctrl[down_timer_pkg::BIT_OUT_MODE_HI],
	                   s_r.ctrl[down_timer_pkg::BIT_OUT_MODE_LO]};

	assign div_tick = (s_r.div == down_timer_pkg::DIV_LAST);
	// event edge, or oscillator reference without a pin
	assign ev_tick  = HAS_INPUT_PIN ? pin_fall[0] : pin_rise[1];

	// Tick selection per input mode
	always_comb begin
		if (!in_en) begin
			tick_src = div_tick;
		end else if (in_mode == down_timer_pkg::IN_EVENT) begin
			tick_src = ev_tick;
		end else if (in_mode == down_timer_pkg::IN_GATED) begin
			tick_src = div_tick & pin_lvl[0];
		end else if (in_mode == down_timer_pkg::IN_TRIGGER) begin
			tick_src = div_tick & s_r.armed;
		end else begin
			tick_src = div_tick;
		end
	end
	assign retrig = run & in_en & (in_mode == down_timer_pkg::IN_RETRIG)
	              & pin_fall[0];
	// count advances when prescaler is at zero
	assign count_tick = run & tick_src & (s_r.presc_cnt == 8'h00) & ~retrig;
	assign eoc = count_tick & (s_r.cnt == 16'h0000);
	// APB phases and address decode
	assign setup = psel & ~penable;
	assign acc   = psel & penable & s_r.pready;
	assign wr    = acc & pwrite;
	always_comb begin
		hit_hi = 1'b0;
		hit_lo = 1'b0;
		hit_ps = 1'b0;
		hit_ct = 1'b0;
		if (paddr == down_timer_pkg::ADDR_COUNT_HIGH) begin
			hit_hi = 1'b1;
		end else if (paddr == down_timer_pkg::ADDR_COUNT_LOW) begin
			hit_lo = 1'b1;
		end else if (paddr == down_timer_pkg::ADDR_PRESCALE) begin
			hit_ps = 1'b1;
		end else if (paddr == down_timer_pkg::ADDR_CONTROL) begin
			hit_ct = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		s_nxt     = s_r;
		s_nxt.div = s_r.div + 2'h1;
		if (!run) begin
			s_nxt.armed = 1'b0;
		end else if (in_en && in_mode == down_timer_pkg::IN_TRIGGER
		             && pin_fall[0]) begin
			s_nxt.armed = 1'b1;
		end
		if (retrig) begin
			s_nxt.cnt       = s_r.reload;
			s_nxt.presc_cnt = s_r.presc_val;
		end else if (run && tick_src) begin
			if (s_r.presc_cnt == 8'h00) begin
				s_nxt.presc_cnt = s_r.presc_val;
				if (s_r.cnt == 16'h0000) begin
					s_nxt.cnt  = s_r.reload;
					s_nxt.pend = 1'b0;
					if (single) begin
						s_nxt.ctrl[down_timer_pkg::BIT_RUN] = 1'b0;
					end
				end else begin
					s_nxt.cnt = s_r.cnt - 16'h0001;
				end
			end else begin
				s_nxt.presc_cnt = s_r.presc_cnt - 8'h01;
			end
		end
		if (out_mode == down_timer_pkg::OUT_NONE) begin
			s_nxt.out = 1'b1;
		end else if (eoc) begin
			if (out_mode == down_timer_pkg::OUT_SQUARE) begin
				s_nxt.out = ~s_r.out;
			end else begin
				s_nxt.out = s_r.ctrl[down_timer_pkg::BIT_OUT_MODE_LO];
			end
		end
		if (s_r.ctrl[down_timer_pkg::BIT_IRQ_ROUTE]) begin
			s_nxt.irq = pin_lvl[2];
		end else begin
			s_nxt.irq = eoc;
		end
		// Register writes, taken at the completing access edge
		if (wr && hit_hi) begin
			// constant only, loaded at end of count
			s_nxt.reload[15:8] = pwdata[7:0];
			s_nxt.pend         = s_nxt.pend | ~run;
		end else if (wr && hit_lo) begin
			s_nxt.reload[7:0] = pwdata[7:0];
			s_nxt.pend        = s_nxt.pend | ~run;
		end else if (wr && hit_ps) begin
			s_nxt.presc_val = pwdata[7:0];
			s_nxt.presc_cnt = pwdata[7:0];
		end else if (wr && hit_ct) begin
			// whole byte, single select and run together
			s_nxt.ctrl = pwdata[7:0];
			if (!run && pwdata[down_timer_pkg::BIT_RUN] && s_r.pend) begin
				s_nxt.cnt       = s_r.reload;
				s_nxt.presc_cnt = s_r.presc_val;
				s_nxt.pend      = 1'b0;
			end
		end
		// Answer in the cycle after setup
		s_nxt.pready  = setup;
		s_nxt.pslverr = setup & ~(hit_hi | hit_lo | hit_ps | hit_ct);
		if (setup && !pwrite) begin
			if (hit_hi) begin
				s_nxt.prdata = {24'h0, s_r.cnt[15:8]};
			end else if (hit_lo) begin
				s_nxt.prdata = {24'h0, s_r.cnt[7:0]};
			end else if (hit_ps) begin
				s_nxt.prdata = {24'h0, s_r.presc_val};
			end else if (hit_ct) begin
				s_nxt.prdata = {24'h0, s_r.ctrl};
			end else begin
				s_nxt.prdata = 32'h0000_0000;
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r           <= '0;
			s_r.cnt       <= {down_timer_pkg::RST_COUNT_HIGH,
			                  down_timer_pkg::RST_COUNT_LOW};
			s_r.reload    <= {down_timer_pkg::RST_COUNT_HIGH,
			                  down_timer_pkg::RST_COUNT_LOW};
			s_r.presc_val <= down_timer_pkg::RST_PRESCALE;
			s_r.presc_cnt <= down_timer_pkg::RST_PRESCALE;
			s_r.ctrl      <= down_timer_pkg::RST_CONTROL;
			s_r.out       <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign prdata          = s_r.prdata;
	assign pready          = s_r.pready;
	assign pslverr         = s_r.pslverr;
	assign timer_out_pin   = s_r.out;
	assign irq_channel_out = s_r.irq;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic ctrl_wr, ps_wr;
	assign ctrl_wr = wr & hit_ct;
	assign ps_wr   = wr & hit_ps;

	sequence s_end_of_count;
		eoc && !ctrl_wr;
	endsequence
	sequence s_stopped_quiet;
		!run && !ctrl_wr;
	endsequence
	property p_count_step;
		count_tick && s_r.cnt != 16'h0000 |=> s_r.cnt == $past(s_r.cnt) - 16'h0001;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("counter did not step down by one");
	property p_reload_eoc;
		eoc |=> s_r.cnt == $past(s_r.reload);
	endproperty
	a_reload_eoc: assert property (p_reload_eoc)
		else $error("counter not reloaded at end of count");
	property p_hold_stopped;
		s_stopped_quiet |=> $stable(s_r.cnt);
	endproperty
	a_hold_stopped: assert property (p_hold_stopped)
		else $error("counter moved while stopped");
	property p_single_stop;
		s_end_of_count and single |=> !run;
	endproperty
	a_single_stop: assert property (p_single_stop)
		else $error("single mode did not clear run bit");
	property p_cont_run;
		s_end_of_count and !single |=> run;
	endproperty
	a_cont_run: assert property (p_cont_run)
		else $error("continuous mode stopped at end of count");
	property p_presc_period;
		run && tick_src && !retrig && !ps_wr && s_r.presc_cnt == 8'h00
		|=> s_r.presc_cnt == $past(s_r.presc_val);
	endproperty
	a_presc_period: assert property (p_presc_period)
		else $error("prescaler not reloaded with its value");
	property p_no_output;
		out_mode == down_timer_pkg::OUT_NONE |=> timer_out_pin;
	endproperty
	a_no_output: assert property (p_no_output)
		else $error("output pin not high in no-output mode");
	property p_square;
		eoc && out_mode == down_timer_pkg::OUT_SQUARE
		|=> timer_out_pin != $past(timer_out_pin);
	endproperty
	a_square: assert property (p_square)
		else $error("square output did not toggle");
	property p_pwm;
		eoc && s_r.ctrl[down_timer_pkg::BIT_OUT_MODE_HI]
		|=> timer_out_pin == $past(s_r.ctrl[down_timer_pkg::BIT_OUT_MODE_LO]);
	endproperty
	a_pwm: assert property (p_pwm)
		else $error("pwm output did not follow mode bit");
	property p_irq_route;
		!s_r.ctrl[down_timer_pkg::BIT_IRQ_ROUTE]
		|=> irq_channel_out == $past(eoc);
	endproperty
	a_irq_route: assert property (p_irq_route)
		else $error("timer request not on interrupt channel");
	property p_presc_read;
		setup && !pwrite && hit_ps ##1 !ps_wr
		|-> prdata == {24'h0, $past(s_r.presc_val)};
	endproperty
	a_presc_read: assert property (p_presc_read)
		else $error("prescaler read not the programmed value");
	property p_retrig;
		retrig |=> s_r.cnt == $past(s_r.reload)
		        && s_r.presc_cnt == $past(s_r.presc_val);
	endproperty
	a_retrig: assert property (p_retrig)
		else $error("retrigger did not reload constants");

endmodule

`default_nettype wire

// file: include/down_timer_pkg.sv
// Shared constants of the general-purpose down timer
package down_timer_pkg;

	// ------------------------------------------------------------
	// Register indices and byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0]  IDX_COUNT_HIGH = 8'hF0;
	localparam logic [7:0]  IDX_COUNT_LOW  = 8'hF1;
	localparam logic [7:0]  IDX_PRESCALE   = 8'hF2;
	localparam logic [7:0]  IDX_CONTROL    = 8'hF3;
	localparam logic [11:0] ADDR_COUNT_HIGH = {2'h0, IDX_COUNT_HIGH, 2'h0};
	localparam logic [11:0] ADDR_COUNT_LOW  = {2'h0, IDX_COUNT_LOW, 2'h0};
	localparam logic [11:0] ADDR_PRESCALE   = {2'h0, IDX_PRESCALE, 2'h0};
	localparam logic [11:0] ADDR_CONTROL    = {2'h0, IDX_CONTROL, 2'h0};

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_COUNT_HIGH = 8'hFF;
	localparam logic [7:0] RST_COUNT_LOW  = 8'hFF;
	localparam logic [7:0] RST_PRESCALE   = 8'hFF;
	localparam logic [7:0] RST_CONTROL    = 8'h14;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int BIT_RUN        = 7;
	localparam int BIT_SINGLE     = 6;
	localparam int BIT_IN_MODE_HI = 5;
	localparam int BIT_IN_MODE_LO = 4;
	localparam int BIT_IN_ENABLE  = 3;
	localparam int BIT_IRQ_ROUTE  = 2;
	localparam int BIT_OUT_MODE_HI = 1;
	localparam int BIT_OUT_MODE_LO = 0;

	// Input modes, {input_mode_hi, input_mode_lo}
	localparam logic [1:0] IN_EVENT   = 2'h0;
	localparam logic [1:0] IN_GATED   = 2'h1;
	localparam logic [1:0] IN_TRIGGER = 2'h2;
	localparam logic [1:0] IN_RETRIG  = 2'h3;

	// Output modes, {output_mode_hi, output_mode_lo}
	localparam logic [1:0] OUT_NONE   = 2'h0;
	localparam logic [1:0] OUT_SQUARE = 2'h1;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int         CORE_DIVIDE = 4;
	localparam logic [1:0] DIV_LAST    = 2'(CORE_DIVIDE - 1);

endpackage

// file: design/pin_sync.sv
// Two-stage synchroniser with edge detection for asynchronous pins
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int               WIDTH     = 3,
	parameter logic [WIDTH-1:0] RST_LEVEL = '1
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Asynchronous pins
	input  wire logic [WIDTH-1:0] pin_in,
	// Synchronised level and edge pulses
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] fall,
	output logic      [WIDTH-1:0] rise
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
		logic [WIDTH-1:0] prev;
	} sync_state_t;

	sync_state_t s_r;
	sync_state_t s_nxt;

	// Shift chain; the first stage feeds only the second
	always_comb begin
		s_nxt      = s_r;
		s_nxt.meta = pin_in;
		s_nxt.sync = s_r.meta;
		s_nxt.prev = s_r.sync;
	end

	// Each stage resets to its pin's idle level, so no false edge follows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= {RST_LEVEL, RST_LEVEL, RST_LEVEL};
		end else begin
			s_r <= s_nxt;
		end
	end

	// Edge pulses, one cycle each, from the settled stages only
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_edge
			assign level[i] = s_r.sync[i];
			assign fall[i]  = s_r.prev[i] & ~s_r.sync[i];
			assign rise[i]  = ~s_r.prev[i] & s_r.sync[i];
		end
	endgenerate

endmodule

`default_nettype wire

// file: testbench/timer_pin_source.sv
// Model of the event source and interrupt pin outside the timer
`timescale 1ns/1ps
`default_nettype none

module timer_pin_source (
	// Clock
	input  wire logic pclk,
	// Pins towards the timer
	output logic      timer_in_pin,
	output logic      ext_irq_pin
);
	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------

	// Idle levels: input high, interrupt low
	initial begin
		timer_in_pin = 1'b1;
		ext_irq_pin  = 1'b0;
	end

	// Set both pin levels just after an edge
	task automatic set_pins(input logic tin, input logic irq);
		@(posedge pclk);
		timer_in_pin <= tin;
		ext_irq_pin  <= irq;
	endtask

	// edge spacing kept
	// Falling edges never closer than eight clocks
	task automatic fall_edges(input int n, input int gap);
		int g;
		g = (gap < 8) ? 8 : gap;
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			timer_in_pin <= 1'b0;
			repeat (g / 2) @(posedge pclk);
			timer_in_pin <= 1'b1;
			repeat (g - g / 2 - 1) @(posedge pclk);
		end
	endtask
endmodule
`default_nettype wire

// file: testbench/basic_down_timer_tb_top.sv
// Self-checking testbench of the down timer
`timescale 1ns/1ps
`default_nettype none

module basic_down_timer_tb_top;
	localparam logic [11:0] A_HI = down_timer_pkg::ADDR_COUNT_HIGH;
	localparam logic [11:0] A_LO = down_timer_pkg::ADDR_COUNT_LOW;
	localparam logic [11:0] A_PS = down_timer_pkg::ADDR_PRESCALE;
	localparam logic [11:0] A_CT = down_timer_pkg::ADDR_CONTROL;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        timer_in_pin;
	logic        ext_irq_pin;
	logic        timer_out_pin;
	logic        irq_channel_out;
	logic [31:0] last_rd;
	int          num_errors;
	int          n_checks;
	int          n_irq;
	int          cyc;
	int          t0;
	int          n0;

	// ------------------------------------------------------------
	// Clock, design and partner
	// ------------------------------------------------------------
	initial pclk = 1'b0;
	always #4 pclk = ~pclk;

	basic_down_timer u_dut (
		.pclk              (pclk),
		.presetn           (presetn),
		.psel              (psel),
		.penable           (penable),
		.pwrite            (pwrite),
		.paddr             (paddr),
		.pwdata            (pwdata),
		.prdata            (prdata),
		.pready            (pready),
		.pslverr           (pslverr),
		.timer_in_pin      (timer_in_pin),
		.osc_time_reference(1'b0),
		.timer_out_pin     (timer_out_pin),
		.ext_irq_pin       (ext_irq_pin),
		.irq_channel_out   (irq_channel_out)
	);

	timer_pin_source u_src (
		.pclk        (pclk),
		.timer_in_pin(timer_in_pin),
		.ext_irq_pin (ext_irq_pin)
	);

	// Cycle and interrupt pulse counters
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (irq_channel_out === 1'b1) begin
			n_irq <= n_irq + 1;
		end
	end

	// ------------------------------------------------------------
	// Checking and bus tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic results;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// One APB transfer; waits for pready under a bound
	task automatic acc(input logic w, input logic [11:0] a,
		input logic [7:0] d, input logic [7:0] e, input logic err,
		input bit cmp);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			chk("pready", 32'h1, 32'h0);
			results();
		end
		last_rd = prdata;
		if (cmp) begin
			chk("pslverr", {31'h0, err}, {31'h0, pslverr});
			if (!w) chk("prdata", {24'h000000, e}, prdata);
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		acc(1'b1, a, d, 8'h00, 1'b0, 1'b1);
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00, e, 1'b0, 1'b1);
	endtask

	// Wait for the next interrupt pulse
	task automatic wait_irq(input int bound);
		int k;
		k = n_irq;
		for (int i = 0; i < bound && n_irq == k; i++) @(posedge pclk);
		chk("irq pulse seen", 32'h1, {31'h0, n_irq != k});
		if (n_irq == k) begin
			results();
		end
		t0 = cyc;
	endtask

	task automatic quiet(input int n);
		n0 = n_irq;
		repeat (n) @(posedge pclk);
		chk("no irq pulse", n0, n_irq);
	endtask

	// Bound on the whole run
	initial begin
		repeat (20000) @(posedge pclk);
		chk("run timeout", 32'h1, 32'h0);
		results();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr  = 12'h000;
		pwdata = 32'h00000000;
		{n_irq, cyc, num_errors, n_checks} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(A_HI, 8'hFF);
		rd(A_LO, 8'hFF);
		rd(A_PS, 8'hFF);
		rd(A_CT, 8'h14);
		chk("out pin", 32'h1, {31'h0, timer_out_pin});
		chk("reset irq", 32'h0, n_irq);
		acc(1'b1, 12'h3D0, 8'h5A, 8'h00, 1'b1, 1'b1);
		acc(1'b0, 12'h3D0, 8'h00, 8'h00, 1'b1, 1'b1);
		// Single mode, square output, timer interrupt
		wr(A_HI, 8'h00);
		wr(A_LO, 8'h03);
		wr(A_PS, 8'h00);
		wr(A_CT, 8'hC1);
		wait_irq(40);
		repeat (2) @(posedge pclk);
		chk("square out", 32'h0, {31'h0, timer_out_pin});
		rd(A_CT, 8'h41);
		rd(A_LO, 8'h03);
		quiet(60);
		// Continuous PWM, divide by two
		wr(A_PS, 8'h01);
		wr(A_LO, 8'h01);
		wr(A_CT, 8'h83);
		wait_irq(40);
		n0 = t0;
		wait_irq(40);
		chk("period", 32'd16, t0 - n0);
		chk("pwm out", 32'h1, {31'h0, timer_out_pin});
		wr(A_LO, 8'h03);
		wait_irq(40);
		n0 = t0;
		wait_irq(60);
		chk("new period", 32'd32, t0 - n0);
		wr(A_CT, 8'h82);
		wait_irq(60);
		repeat (2) @(posedge pclk);
		chk("pwm out", 32'h0, {31'h0, timer_out_pin});
		wr(A_CT, 8'h00);
		repeat (3) @(posedge pclk);
		chk("idle out", 32'h1, {31'h0, timer_out_pin});
		// Live read, stop, resume, new constant
		wr(A_PS, 8'h00);
		wr(A_HI, 8'h10);
		wr(A_LO, 8'h00);
		wr(A_CT, 8'h80);
		repeat (30) @(posedge pclk);
		rd(A_HI, 8'h0F);
		wr(A_CT, 8'h00);
		acc(1'b0, A_LO, 8'h00, 8'h00, 1'b0, 1'b0);
		repeat (40) @(posedge pclk);
		rd(A_LO, last_rd[7:0]);
		wr(A_CT, 8'h80);
		rd(A_HI, 8'h0F);
		wr(A_CT, 8'h00);
		wr(A_PS, 8'h03);
		wr(A_HI, 8'h20);
		wr(A_CT, 8'h80);
		rd(A_HI, 8'h20);
		rd(A_PS, 8'h03);
		wr(A_CT, 8'h00);
		// Gated input, then input section off
		wr(A_PS, 8'h00);
		wr(A_HI, 8'h00);
		wr(A_LO, 8'h02);
		u_src.set_pins(1'b0, 1'b0);
		wr(A_CT, 8'h98);
		quiet(80);
		u_src.set_pins(1'b1, 1'b0);
		wait_irq(40);
		u_src.set_pins(1'b0, 1'b0);
		wr(A_CT, 8'h90);
		wait_irq(40);
		wr(A_CT, 8'h00);
		// Event counting on falling edges
		u_src.set_pins(1'b1, 1'b0);
		wr(A_LO, 8'h02);
		wr(A_CT, 8'h88);
		n0 = n_irq;
		u_src.fall_edges(2, 10);
		repeat (20) @(posedge pclk);
		chk("events", n0, n_irq);
		u_src.fall_edges(1, 10);
		repeat (10) @(posedge pclk);
		chk("events", n0 + 1, n_irq);
		wr(A_CT, 8'h00);
		// Triggered start, then retriggering
		wr(A_LO, 8'h03);
		wr(A_CT, 8'hA8);
		quiet(60);
		u_src.fall_edges(1, 10);
		wait_irq(40);
		wr(A_CT, 8'h00);
		wr(A_LO, 8'h10);
		wr(A_CT, 8'hB8);
		n0 = n_irq;
		u_src.fall_edges(4, 40);
		chk("retrigger", n0, n_irq);
		wait_irq(90);
		// External pin owns the channel
		wr(A_LO, 8'h03);
		wr(A_CT, 8'h84);
		quiet(80);
		u_src.set_pins(1'b1, 1'b1);
		repeat (5) @(posedge pclk);
		chk("irq route", 32'h1, {31'h0, irq_channel_out});
		u_src.set_pins(1'b1, 1'b0);
		repeat (5) @(posedge pclk);
		chk("irq route", 32'h0, {31'h0, irq_channel_out});
		results();
	end
endmodule
`default_nettype wire
